// ===== verilog/pintc_pkg.sv
// shared constants of the priority interrupt controller
package pintc_pkg;
	// sizes
	localparam int NSRC = 48;
	localparam int NFLD = 42;
	localparam int NPRIO = 11;
	localparam int NTRAP = 4;
	localparam int NCN = 10;
	localparam int NEXT = 3;
	// register indices, byte address is four times the index
	localparam logic [9:0] IDX_FLAGS0 = 10'h000;
	localparam logic [9:0] IDX_ENABLES0 = 10'h003;
	localparam logic [9:0] IDX_PRIO0 = 10'h006;
	localparam logic [9:0] IDX_CPU_LEVEL = 10'h011;
	localparam logic [9:0] IDX_GCTRL1 = 10'h012;
	localparam logic [9:0] IDX_GCTRL2 = 10'h013;
	localparam logic [9:0] IDX_IRQ_STAT = 10'h014;
	localparam logic [9:0] IDX_CN_EN_LO = 10'h0c0;
	localparam logic [9:0] IDX_CN_EN_HI = 10'h0c2;
	localparam logic [9:0] IDX_CN_PU_LO = 10'h0c4;
	localparam logic [9:0] IDX_CN_PU_HI = 10'h0c6;
	// reset value and writable bits
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] FULL_MASK = 16'hffff;
	localparam logic [15:0] PRIO_MASK = 16'h7777;
	localparam logic [15:0] PRIO_LAST_MASK = 16'h0077;
	localparam logic [15:0] CN_LO_MASK = 16'h00ff;
	localparam logic [15:0] CN_HI_MASK = 16'h0006;
	localparam logic [15:0] GC1_MASK = 16'h800f;
	localparam logic [15:0] GC2_MASK = 16'h8007;
	// field positions
	localparam int GC1_NEST_BIT = 15;
	localparam int GC1_ADDR_TRAP_BIT = 2;
	localparam int GC2_ALT_BIT = 15;
	localparam int GC2_TIMED_BIT = 14;
	localparam int CN_FLAG_BIT = 15;
	localparam int EXT0_BIT = 0;
	localparam int EXT1_BIT = 16;
	localparam int EXT2_BIT = 23;
	// levels, vectors and program addresses
	localparam logic [3:0] TRAP_LEVEL_BASE = 4'h8;
	localparam logic [2:0] TIMED_PASS_LEVEL = 3'h7;
	localparam logic [5:0] IRQ_VECTOR_BASE = 6'h08;
	localparam logic [23:0] PRI_TABLE_BASE = 24'h000004;
	localparam logic [23:0] ALT_TABLE_BASE = 24'h000084;
	localparam logic [23:0] VEC_SPACE_LO = 24'h000004;
	localparam logic [23:0] VEC_SPACE_HI = 24'h0000fe;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// byte-lane merge of a 16-bit register write
	function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] strb, input logic [15:0] mask);
		logic [15:0] m;
		m = {{8{strb[1]}}, {8{strb[0]}}} & mask;
		return (old & ~m) | (nw & m);
	endfunction : wmerge
endpackage : pintc_pkg

// ===== verilog/pintc_pin_events.sv
// pin synchronisers with change and edge detection
`timescale 1ns/1ps
module pintc_pin_events (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pins and controls
	input wire logic [pintc_pkg::NCN-1:0] cn_pin,
	input wire logic [pintc_pkg::NCN-1:0] cn_enable,
	input wire logic [pintc_pkg::NEXT-1:0] ext_pin,
	input wire logic [pintc_pkg::NEXT-1:0] ext_falling,
	// events
	output logic cn_event,
	output logic [pintc_pkg::NEXT-1:0] ext_event
);
	import pintc_pkg::*;
	localparam int NP = NCN + NEXT;
	logic [NP-1:0] meta_q;
	logic [NP-1:0] sync_q;
	logic [NP-1:0] prev_q;
	logic [2:0] prime_q;
	wire logic [NP-1:0] chg_w;
	wire logic [NEXT-1:0] edge_w;

	// a change is compared only once prev holds a real sample
	assign chg_w = sync_q ^ prev_q;
	assign edge_w = chg_w[NP-1:NCN] & (sync_q[NP-1:NCN] ^ ext_falling);

	// two-stage synchroniser, history and registered events
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
			prime_q <= 3'h0;
			cn_event <= 1'b0;
			ext_event <= '0;
		end else begin
			meta_q <= {ext_pin, cn_pin};
			sync_q <= meta_q;
			prev_q <= sync_q;
			prime_q <= {prime_q[1:0], 1'b1};
			cn_event <= prime_q[2] && (|(chg_w[NCN-1:0] & cn_enable));
			ext_event <= prime_q[2] ? edge_w : '0;
		end
	end
endmodule : pintc_pin_events

// ===== verilog/pintc_arbiter.sv
// picks the highest-priority eligible source, lowest index on a tie
`timescale 1ns/1ps
module pintc_arbiter (
	// candidates
	input wire logic [pintc_pkg::NFLD-1:0] pend,
	input wire logic [3*pintc_pkg::NFLD-1:0] prio,
	// masking state
	input wire logic [3:0] cpu_level,
	input wire logic timed_block,
	input wire logic nest_block,
	// winner
	output logic valid,
	output logic [5:0] src,
	output logic [2:0] level
);
	import pintc_pkg::*;
	logic [2:0] lvl;

	// strict greater keeps the earlier source on equal levels
	always_comb begin
		level = 3'h0;
		src = 6'h00;
		lvl = 3'h0;
		for (int i = 0; i < NFLD; i++) begin
			lvl = prio[3*i+:3];
			if (pend[i] && lvl > level && {1'b0, lvl} > cpu_level &&
				!(timed_block && lvl != TIMED_PASS_LEVEL)) begin
				level = lvl;
				src = 6'(i);
			end
		end
	end

	// level zero never wins, nesting lock hides everything
	assign valid = (level != 3'h0) && !nest_block;
endmodule : pintc_arbiter

// ===== verilog/pintc_top.sv
// priority interrupt controller: register slave, flags, priority, core handshake
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
//
// Overview of operation
// - arbitrate peripheral sources and four traps
// - flags set by hardware, cleared by software
// - flags set regardless of enable bit
// - only enabled sources are processed
// - eleven priority registers, last one half
// - seven maskable levels, seven is highest
// - priority zero means never processed
// - four-bit cpu priority level held here
// - nesting disable blocks new interrupts
// - nesting disable makes cpu level read-only
// - timed disable blocks levels six and below
// - two global control registers hold controls
// - trigger options stay in the peripherals; here the external pin edge polarity sits in GCTRL2 bits 2:0
// - vector word loads the program counter
// - vector tables at fixed program addresses
// - fetch from vector space raises trap
// - enabled pin change raises a request
// - ten selectable change channels
// - three-bit fields, nibble top bit zero
// - equal levels served in natural order
// - traps at levels eight and above
module pintc_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus write channels
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// register bus read channels
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// request sources
	input wire logic [pintc_pkg::NSRC-1:0] periph_event,
	input wire logic [pintc_pkg::NTRAP-1:0] trap_event,
	input wire logic [pintc_pkg::NEXT-1:0] ext_pin,
	input wire logic [pintc_pkg::NCN-1:0] cn_pin,
	output logic [pintc_pkg::NCN-1:0] cn_pullup_en,
	// interrupt handshake with the core
	output logic irq_req,
	output logic [5:0] irq_vector_num,
	output logic [2:0] irq_level,
	output logic [23:0] irq_vector_addr,
	input wire logic irq_ack,
	input wire logic irq_done,
	input wire logic [3:0] irq_restore_level,
	output logic trap_req,
	output logic [3:0] trap_level,
	input wire logic trap_ack,
	output logic [3:0] cpu_level,
	// timed disable
	input wire logic timed_start,
	input wire logic [13:0] timed_count,
	input wire logic instr_retire,
	// vector load and fetch guard
	input wire logic vec_word_valid,
	input wire logic [23:0] vec_word,
	output logic pc_load_valid,
	output logic [23:0] pc_load_value,
	input wire logic fetch_valid,
	input wire logic [23:0] fetch_addr,
	input wire logic vector_read,
	output logic addr_error_trap
);
	import pintc_pkg::*;

	logic [2:0][15:0] flags_q, flags_d;
	logic [2:0][15:0] en_q, en_d;
	logic [NPRIO-1:0][15:0] prio_q, prio_d;
	logic [15:0] cn_en_lo_q, cn_en_hi_q, cn_pu_lo_q, cn_pu_hi_q;
	logic [15:0] gc1_q, gc1_d, gc2_q;
	logic [3:0] cpu_level_q, cpu_level_d;
	logic [3:0] in_service_q;
	logic [13:0] timed_cnt_q;
	logic bvalid_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [3*NFLD-1:0] prio_fld_w;
	wire logic wr_go_w, rd_go_w, flag_wr_any_w, cpu_wr_w;
	wire logic [9:0] wr_idx_w, rd_idx_w;
	wire logic [15:0] wd_w;
	wire logic [1:0] ws_w;
	wire logic [16:0] rd_w;
	wire logic [NSRC-1:0] set_evt_w, flags_flat_w, en_flat_w;
	wire logic cn_event_w;
	wire logic [NEXT-1:0] ext_event_w;
	wire logic arb_valid_w, timed_on_w, nest_block_w, addr_err_w;
	wire logic [5:0] arb_src_w;
	wire logic [2:0] arb_level_w;
	wire logic [1:0] trap_idx_w;
	wire logic [23:0] table_base_w;

	// register access decode
	function automatic logic wr_at(input logic [9:0] idx);
		return wr_go_w && wr_idx_w == idx;
	endfunction : wr_at

	function automatic logic in_range(input logic [9:0] idx, input logic [9:0] lo, input int n);
		return idx >= lo && idx < lo + 10'(n);
	endfunction : in_range

	// read mux, top bit marks a mapped index
	function automatic logic [16:0] rd_sel(input logic [9:0] idx);
		logic [16:0] r;
		r = {1'b0, 16'h0000};
		if (in_range(idx, IDX_FLAGS0, 3))
			r = {1'b1, flags_q[2'(idx - IDX_FLAGS0)]};
		else if (in_range(idx, IDX_ENABLES0, 3))
			r = {1'b1, en_q[2'(idx - IDX_ENABLES0)]};
		else if (in_range(idx, IDX_PRIO0, NPRIO))
			r = {1'b1, prio_q[4'(idx - IDX_PRIO0)]};
		else begin
			case (idx)
				IDX_CPU_LEVEL: r = {1'b1, 12'h000, cpu_level_q};
				IDX_GCTRL1: r = {1'b1, gc1_q};
				IDX_GCTRL2: r = {1'b1, gc2_q | (16'(timed_on_w) << GC2_TIMED_BIT)};
				IDX_IRQ_STAT: r = {1'b1, irq_req, 5'h00, irq_level, 1'b0, irq_vector_num};
				IDX_CN_EN_LO: r = {1'b1, cn_en_lo_q};
				IDX_CN_EN_HI: r = {1'b1, cn_en_hi_q};
				IDX_CN_PU_LO: r = {1'b1, cn_pu_lo_q};
				IDX_CN_PU_HI: r = {1'b1, cn_pu_hi_q};
				default: r = {1'b0, 16'h0000};
			endcase
		end
		return r;
	endfunction : rd_sel

	// bus handshakes: a write is taken with address and data together
	assign wr_go_w = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign rd_go_w = s_axi_arvalid && !rvalid_q;
	assign s_axi_awready = wr_go_w;
	assign s_axi_wready = wr_go_w;
	assign s_axi_arready = rd_go_w;
	assign wr_idx_w = s_axi_awaddr[11:2];
	assign rd_idx_w = s_axi_araddr[11:2];
	assign wd_w = s_axi_wdata[15:0];
	assign ws_w = s_axi_wstrb[1:0];
	assign rd_w = rd_sel(rd_idx_w);
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	// bus response registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h00000000;
		end else begin
			if (wr_go_w) begin
				bvalid_q <= 1'b1;
				bresp_q <= rd_sel(wr_idx_w) == 17'h00000 ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bready)
				bvalid_q <= 1'b0;
			if (rd_go_w) begin
				rvalid_q <= 1'b1;
				rresp_q <= rd_w[16] ? RESP_OKAY : RESP_SLVERR;
				rdata_q <= {16'h0000, rd_w[15:0]};
			end else if (s_axi_rready)
				rvalid_q <= 1'b0;
		end
	end

	// pin change and external edge detection
	pintc_pin_events u_pins (
		.aclk(aclk),
		.aresetn(aresetn),
		.cn_pin(cn_pin),
		.cn_enable({cn_en_hi_q[2:1], cn_en_lo_q[7:0]}),
		.ext_pin(ext_pin),
		.ext_falling(gc2_q[2:0]),
		.cn_event(cn_event_w),
		.ext_event(ext_event_w)
	);

	// peripheral set pulses and change channel request
	assign set_evt_w = periph_event | (NSRC'(cn_event_w) << CN_FLAG_BIT) |
		(NSRC'(ext_event_w[0]) << EXT0_BIT) | (NSRC'(ext_event_w[1]) << EXT1_BIT) |
		(NSRC'(ext_event_w[2]) << EXT2_BIT);
	assign flags_flat_w = flags_q;
	assign en_flat_w = en_q;
	assign flag_wr_any_w = wr_go_w && in_range(wr_idx_w, IDX_FLAGS0, 3);
	assign cpu_wr_w = wr_at(IDX_CPU_LEVEL) && !gc1_q[GC1_NEST_BIT];
	assign cn_pullup_en = {cn_pu_hi_q[2:1], cn_pu_lo_q[7:0]};

	always_comb begin
		flags_d = flags_q;
		en_d = en_q;
		prio_d = prio_q;
		for (int i = 0; i < 3; i++) begin
			if (wr_at(IDX_FLAGS0 + 10'(i)))
				flags_d[i] = wmerge(flags_q[i], wd_w, ws_w, FULL_MASK);
			if (wr_at(IDX_ENABLES0 + 10'(i)))
				en_d[i] = wmerge(en_q[i], wd_w, ws_w, FULL_MASK);
			flags_d[i] = flags_d[i] | set_evt_w[16*i+:16];
		end
		for (int i = 0; i < NPRIO; i++)
			if (wr_at(IDX_PRIO0 + 10'(i)))
				prio_d[i] = wmerge(prio_q[i], wd_w, ws_w, i == NPRIO - 1 ? PRIO_LAST_MASK : PRIO_MASK);
		for (int i = 0; i < NFLD; i++)
			prio_fld_w[3*i+:3] = prio_q[i/4][4*(i%4)+:3];
	end

	assign addr_err_w = fetch_valid && !vector_read && fetch_addr >= VEC_SPACE_LO &&
		fetch_addr <= VEC_SPACE_HI;

	// trap status flags set by hardware, cleared by software
	always_comb begin
		gc1_d = wr_at(IDX_GCTRL1) ? wmerge(gc1_q, wd_w, ws_w, GC1_MASK) : gc1_q;
		gc1_d[NTRAP-1:0] = gc1_d[NTRAP-1:0] | trap_event;
		gc1_d[GC1_ADDR_TRAP_BIT] = gc1_d[GC1_ADDR_TRAP_BIT] | addr_err_w;
	end

	// cpu level: hardware updates first, write lock
	always_comb begin
		cpu_level_d = cpu_level_q;
		if (trap_ack)
			cpu_level_d = trap_level;
		else if (irq_ack)
			cpu_level_d = {1'b0, irq_level};
		else if (irq_done)
			cpu_level_d = irq_restore_level;
		else if (cpu_wr_w)
			cpu_level_d = 4'(wmerge({12'h000, cpu_level_q}, wd_w, ws_w, FULL_MASK));
	end

	// register file state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_q <= '0;
			en_q <= '0;
			prio_q <= '0;
			gc1_q <= REG_RESET;
			gc2_q <= REG_RESET;
			cn_en_lo_q <= REG_RESET;
			cn_en_hi_q <= REG_RESET;
			cn_pu_lo_q <= REG_RESET;
			cn_pu_hi_q <= REG_RESET;
			cpu_level_q <= 4'h0;
		end else begin
			flags_q <= flags_d;
			en_q <= en_d;
			prio_q <= prio_d;
			gc1_q <= gc1_d;
			cpu_level_q <= cpu_level_d;
			if (wr_at(IDX_GCTRL2))
				gc2_q <= wmerge(gc2_q, wd_w, ws_w, GC2_MASK);
			if (wr_at(IDX_CN_EN_LO))
				cn_en_lo_q <= wmerge(cn_en_lo_q, wd_w, ws_w, CN_LO_MASK);
			if (wr_at(IDX_CN_EN_HI))
				cn_en_hi_q <= wmerge(cn_en_hi_q, wd_w, ws_w, CN_HI_MASK);
			if (wr_at(IDX_CN_PU_LO))
				cn_pu_lo_q <= wmerge(cn_pu_lo_q, wd_w, ws_w, CN_LO_MASK);
			if (wr_at(IDX_CN_PU_HI))
				cn_pu_hi_q <= wmerge(cn_pu_hi_q, wd_w, ws_w, CN_HI_MASK);
		end
	end

	assign timed_on_w = timed_cnt_q != 14'h0000;
	assign nest_block_w = gc1_q[GC1_NEST_BIT] && in_service_q != 4'h0;

	pintc_arbiter u_arb (
		.pend(flags_flat_w[NFLD-1:0] & en_flat_w[NFLD-1:0]),
		.prio(prio_fld_w),
		.cpu_level(cpu_level_q),
		.timed_block(timed_on_w),
		.nest_block(nest_block_w),
		.valid(arb_valid_w),
		.src(arb_src_w),
		.level(arb_level_w)
	);

	// highest pending trap sits above every interrupt level
	assign trap_idx_w = gc1_q[3] ? 2'd3 : gc1_q[2] ? 2'd2 : gc1_q[1] ? 2'd1 : 2'd0;
	// table selected by the alternate bit
	assign table_base_w = gc2_q[GC2_ALT_BIT] ? ALT_TABLE_BASE : PRI_TABLE_BASE;
	assign cpu_level = cpu_level_q;

	// core handshake, vector load and service tracking
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_req <= 1'b0;
			irq_vector_num <= 6'h00;
			irq_level <= 3'h0;
			irq_vector_addr <= 24'h000000;
			trap_req <= 1'b0;
			trap_level <= TRAP_LEVEL_BASE;
			in_service_q <= 4'h0;
			timed_cnt_q <= 14'h0000;
			pc_load_valid <= 1'b0;
			pc_load_value <= 24'h000000;
			addr_error_trap <= 1'b0;
		end else begin
			irq_req <= arb_valid_w && !irq_ack;
			irq_vector_num <= arb_src_w + IRQ_VECTOR_BASE;
			irq_level <= arb_level_w;
			irq_vector_addr <= table_base_w + {17'h00000, arb_src_w + IRQ_VECTOR_BASE, 1'b0};
			trap_req <= (|gc1_q[NTRAP-1:0]) && !trap_ack &&
				TRAP_LEVEL_BASE + {2'b00, trap_idx_w} > cpu_level_q;
			trap_level <= TRAP_LEVEL_BASE + {2'b00, trap_idx_w};
			if (irq_ack && !irq_done)
				in_service_q <= in_service_q + 4'h1;
			else if (irq_done && !irq_ack && in_service_q != 4'h0)
				in_service_q <= in_service_q - 4'h1;
			if (timed_start)
				timed_cnt_q <= timed_count;
			else if (instr_retire && timed_on_w)
				timed_cnt_q <= timed_cnt_q - 14'h0001;
			// vector word through to the program counter
			pc_load_valid <= vec_word_valid;
			if (vec_word_valid)
				pc_load_value <= vec_word;
			addr_error_trap <= addr_err_w;
		end
	end

	a_flag_sets: assert property (@(posedge aclk) disable iff (!aresetn)
		(|set_evt_w) |=> ((flags_flat_w & $past(set_evt_w)) == $past(set_evt_w)))
		else $error("request flag missed its event");
	a_flag_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!flag_wr_any_w |=> (($past(flags_flat_w) & ~flags_flat_w) == 48'h0))
		else $error("request flag fell without a write");
	a_req_enabled: assert property (@(posedge aclk) disable iff (!aresetn)
		arb_valid_w |-> en_flat_w[arb_src_w] && flags_flat_w[arb_src_w])
		else $error("disabled source presented");
	a_prio_nonzero: assert property (@(posedge aclk) disable iff (!aresetn)
		arb_valid_w |-> arb_level_w != 3'h0 && prio_fld_w[3*arb_src_w+:3] == arb_level_w)
		else $error("level zero source presented");
	a_above_cpu: assert property (@(posedge aclk) disable iff (!aresetn)
		arb_valid_w |-> {1'b0, arb_level_w} > cpu_level_q)
		else $error("request not above cpu level");
	a_no_nesting: assert property (@(posedge aclk) disable iff (!aresetn)
		(gc1_q[GC1_NEST_BIT] && in_service_q != 4'h0) |=> !irq_req)
		else $error("nested request while locked");
	a_level_locked: assert property (@(posedge aclk) disable iff (!aresetn)
		(gc1_q[GC1_NEST_BIT] && !irq_ack && !trap_ack && !irq_done) |=> $stable(cpu_level_q))
		else $error("cpu level changed while locked");
	a_timed_block: assert property (@(posedge aclk) disable iff (!aresetn)
		(timed_start && timed_count != 14'h0000) |=> (!arb_valid_w || arb_level_w == TIMED_PASS_LEVEL)
		&& timed_on_w)
		else $error("timed disable let a low level through");
	a_vector_fetch: assert property (@(posedge aclk) disable iff (!aresetn)
		addr_err_w |=> addr_error_trap && gc1_q[GC1_ADDR_TRAP_BIT])
		else $error("vector space fetch not trapped");
	a_change_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		cn_event_w |=> flags_q[0][CN_FLAG_BIT])
		else $error("pin change did not flag");
	a_nibble_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 (prio_q[NPRIO-1] & ~PRIO_LAST_MASK) == 16'h0000 && (prio_q[0] & ~PRIO_MASK) == 16'h0000)
		else $error("priority nibble top bit set");

	c_irq_taken: cover property (@(posedge aclk) disable iff (!aresetn) irq_req ##1 irq_ack);
	c_nested: cover property (@(posedge aclk) disable iff (!aresetn) irq_ack && in_service_q != 4'h0);
	c_timed: cover property (@(posedge aclk) disable iff (!aresetn) timed_on_w && arb_valid_w);
	c_trap: cover property (@(posedge aclk) disable iff (!aresetn) trap_req ##1 trap_ack);
endmodule : pintc_top

// ===== tb/pintc_core_model.sv
// core model: takes presented interrupts and traps, returns after service
`timescale 1ns/1ps
module pintc_core_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bench control
	input wire logic take_en,
	input wire logic [3:0] ack_delay,
	// handshake with the controller
	input wire logic irq_req,
	input wire logic trap_req,
	input wire logic [3:0] cpu_level,
	output logic irq_ack,
	output logic irq_done,
	output logic [3:0] irq_restore_level,
	output logic trap_ack
);
	logic [3:0] wait_q;
	logic [3:0] svc_q;
	logic [3:0] svc_hold_q;
	// level to hand back at return
	assign irq_restore_level = svc_hold_q;
	// ack only while the request stands, after a chosen wait; return after service
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_ack <= 1'b0;
			irq_done <= 1'b0;
			trap_ack <= 1'b0;
			wait_q <= 4'h0;
			svc_q <= 4'h0;
			svc_hold_q <= 4'h0;
		end else begin
			irq_ack <= 1'b0;
			irq_done <= svc_q == 4'h1;
			trap_ack <= trap_req && !trap_ack;
			wait_q <= (irq_req && svc_q == 4'h0 && !irq_ack) ? wait_q + 4'h1 : 4'h0;
			if (svc_q != 4'h0) begin
				svc_q <= svc_q - 4'h1;
			end
			if (take_en && irq_req && !irq_ack && svc_q == 4'h0 && wait_q >= ack_delay) begin
				irq_ack <= 1'b1;
				svc_q <= 4'h8;
				svc_hold_q <= cpu_level;
			end
		end
	end
endmodule : pintc_core_model

// ===== tb/pintc_top_test.sv
// self-checking bench of the priority interrupt controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("MISMATCH %s expected %h seen %h", nm, e, g); \
	end \
end
module pintc_top_test;
	import pintc_pkg::*;
	logic aclk, aresetn, take_en;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot, irq_level;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, irq_restore_level, trap_level, cpu_level;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_req, irq_ack, irq_done;
	logic trap_req, trap_ack, timed_start, instr_retire, vec_word_valid, pc_load_valid;
	logic fetch_valid, vector_read, addr_error_trap;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [NSRC-1:0] periph_event;
	logic [NTRAP-1:0] trap_event;
	logic [NEXT-1:0] ext_pin;
	logic [NCN-1:0] cn_pin, cn_pullup_en;
	logic [5:0] irq_vector_num;
	logic [23:0] irq_vector_addr, vec_word, pc_load_value, fetch_addr;
	logic [13:0] timed_count;
	logic [15:0] rdat;
	int num_errors = 0;
	int num_checks = 0;
	// design and core model
	pintc_top pintc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .periph_event, .trap_event, .ext_pin, .cn_pin, .cn_pullup_en, .irq_req, .irq_vector_num,
		.irq_level, .irq_vector_addr, .irq_ack, .irq_done, .irq_restore_level, .trap_req, .trap_level, .trap_ack,
		.cpu_level, .timed_start, .timed_count, .instr_retire, .vec_word_valid, .vec_word, .pc_load_valid,
		.pc_load_value, .fetch_valid, .fetch_addr, .vector_read, .addr_error_trap);
	pintc_core_model pintc_core_model_inst (.aclk, .aresetn, .take_en, .ack_delay(4'h3), .irq_req, .trap_req,
		.cpu_level, .irq_ack, .irq_done, .irq_restore_level, .trap_ack);
	// clock
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report
	// one register write, then its response
	task automatic wr(input logic [9:0] idx, input logic [15:0] d);
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		@(negedge aclk);
		while (!(s_axi_awready && s_axi_wready)) @(negedge aclk);
		@(posedge aclk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		@(negedge aclk);
		while (!s_axi_bvalid) @(negedge aclk);
		rsp = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask : wr
	// one register read
	task automatic rd(input logic [9:0] idx);
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(negedge aclk);
		while (!s_axi_arready) @(negedge aclk);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		@(negedge aclk);
		while (!s_axi_rvalid) @(negedge aclk);
		rdat = s_axi_rdata[15:0];
		rsp = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic rd_chk(input logic [9:0] idx, input logic [15:0] e, input string nm);
		rd(idx);
		`CHK(nm, e, rdat)
		`CHK(nm, RESP_OKAY, rsp)
	endtask : rd_chk
	task automatic ev(input logic [NSRC-1:0] m);
		@(posedge aclk);
		periph_event <= m;
		@(posedge aclk);
		periph_event <= '0;
	endtask : ev
	// let n edges pass, then sample at the falling edge
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask : cyc
	// watchdog
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		final_report();
	end
	// main sequence
	initial begin
		aresetn = 1'b0;
		take_en = 1'b0;
		s_axi_wstrb = 4'h3;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot, periph_event, trap_event} = '0;
		{ext_pin, cn_pin, timed_start, timed_count, instr_retire, vec_word_valid, vec_word} = '0;
		{fetch_valid, fetch_addr, vector_read} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 4; i++) rd_chk(IDX_CN_EN_LO + 10'(2 * i), 16'h0000, "cn reset");
		wr(IDX_CN_EN_LO, 16'hffff);
		rd_chk(IDX_CN_EN_LO, 16'h00ff, "cn_en_lo");
		wr(IDX_CN_EN_HI, 16'hffff);
		rd_chk(IDX_CN_EN_HI, 16'h0006, "cn_en_hi");
		wr(IDX_CN_PU_LO, 16'h00a5);
		wr(IDX_CN_PU_HI, 16'h0004);
		cyc(1);
		`CHK("pullups", 10'h2a5, cn_pullup_en)
		rd(10'h0c1);
		`CHK("gap resp", RESP_SLVERR, rsp)
		`CHK("gap data", 16'h0000, rdat)
		wr(IDX_PRIO0, 16'hffff);
		`CHK("wr resp", RESP_OKAY, rsp)
		rd_chk(IDX_PRIO0, 16'h7777, "prio0");
		wr(IDX_PRIO0 + 10'h00a, 16'hffff);
		rd_chk(IDX_PRIO0 + 10'h00a, 16'h0077, "prio last");
		wr(IDX_PRIO0, 16'h0550);
		ev(48'h8);
		rd_chk(IDX_FLAGS0, 16'h0008, "flag set");
		`CHK("irq off", 1'b0, irq_req)
		wr(IDX_FLAGS0, 16'h0000);
		rd_chk(IDX_FLAGS0, 16'h0000, "flag clear");
		wr(IDX_ENABLES0, 16'h000e);
		ev(48'h8);
		cyc(3);
		`CHK("prio zero", 1'b0, irq_req)
		wr(IDX_PRIO0, 16'h3550);
		cyc(2);
		`CHK("irq on", 1'b1, irq_req)
		`CHK("vector", 6'd11, irq_vector_num)
		`CHK("level", 3'd3, irq_level)
		`CHK("vec addr", PRI_TABLE_BASE + 24'd22, irq_vector_addr)
		wr(IDX_CPU_LEVEL, 16'h0003);
		cyc(2);
		`CHK("equal level", 1'b0, irq_req)
		rd_chk(IDX_CPU_LEVEL, 16'h0003, "cpu level");
		wr(IDX_CPU_LEVEL, 16'h0002);
		cyc(2);
		`CHK("above level", 1'b1, irq_req)
		wr(IDX_CPU_LEVEL, 16'h0000);
		ev(48'h6);
		cyc(3);
		`CHK("tie vector", 6'd9, irq_vector_num)
		`CHK("tie level", 3'd5, irq_level)
		@(posedge aclk);
		timed_start <= 1'b1;
		timed_count <= 14'd2;
		@(posedge aclk);
		timed_start <= 1'b0;
		cyc(2);
		`CHK("timed block", 1'b0, irq_req)
		rd_chk(IDX_GCTRL2, 16'h4000, "timed bit");
		@(posedge aclk);
		instr_retire <= 1'b1;
		repeat (2) @(posedge aclk);
		instr_retire <= 1'b0;
		cyc(3);
		`CHK("timed over", 1'b1, irq_req)
		wr(IDX_GCTRL1, 16'h8000);
		wr(IDX_CPU_LEVEL, 16'h0004);
		rd_chk(IDX_CPU_LEVEL, 16'h0000, "level locked");
		@(posedge aclk);
		take_en <= 1'b1;
		@(negedge aclk);
		while (!irq_ack) @(negedge aclk);
		@(posedge aclk);
		take_en <= 1'b0;
		cyc(1);
		`CHK("ack level", 4'h5, cpu_level)
		`CHK("ack drop", 1'b0, irq_req)
		cyc(10);
		`CHK("restored", 4'h0, cpu_level)
		@(posedge aclk);
		vec_word_valid <= 1'b1;
		vec_word <= 24'h12abcd;
		@(posedge aclk);
		vec_word_valid <= 1'b0;
		@(negedge aclk);
		`CHK("pc load", 25'h112abcd, {pc_load_valid, pc_load_value})
		@(posedge aclk);
		fetch_valid <= 1'b1;
		vector_read <= 1'b1;
		fetch_addr <= VEC_SPACE_HI;
		@(posedge aclk);
		vector_read <= 1'b0;
		@(negedge aclk);
		`CHK("vector read", 1'b0, addr_error_trap)
		@(posedge aclk);
		fetch_valid <= 1'b0;
		@(negedge aclk);
		`CHK("fetch trap", 1'b1, addr_error_trap)
		cyc(4);
		`CHK("trap level", 4'ha, cpu_level)
		`CHK("masked", 1'b0, irq_req)
		`CHK("trap req", 1'b0, trap_req)
		rd_chk(IDX_GCTRL1, 16'h8004, "trap bit");
		wr(IDX_GCTRL1, 16'h0000);
		wr(IDX_CPU_LEVEL, 16'h0000);
		wr(IDX_CN_EN_LO, 16'h00fe);
		wr(IDX_FLAGS0, 16'h0000);
		@(posedge aclk);
		cn_pin <= 10'h001;
		cyc(6);
		rd_chk(IDX_FLAGS0, 16'h0000, "cn off");
		@(posedge aclk);
		cn_pin <= 10'h003;
		cyc(6);
		rd_chk(IDX_FLAGS0, 16'h8000, "cn on");
		wr(IDX_ENABLES0, 16'h0001);
		wr(IDX_PRIO0, 16'h0001);
		wr(IDX_GCTRL2, 16'h8001);
		@(posedge aclk);
		ext_pin <= 3'h1;
		cyc(6);
		`CHK("ext rise", 1'b0, irq_req)
		@(posedge aclk);
		ext_pin <= 3'h0;
		cyc(6);
		`CHK("ext fall", 1'b1, irq_req)
		`CHK("alt vector", ALT_TABLE_BASE + 24'd16, irq_vector_addr)
		@(posedge aclk);
		trap_event <= 4'h8;
		@(posedge aclk);
		trap_event <= 4'h0;
		cyc(4);
		`CHK("trap 3 level", 4'hb, cpu_level)
		final_report();
	end
endmodule : pintc_top_test
